// ===== src/dro_defs.svh
// offsets, field positions, reset values and limits of the operand formatter
//
// Notes on behaviour
// - reset: interrupt mask ones, repeat, modulo, reserved zero
// - reset clears vector base and DSP status
// - reset loads stack pointer and PC from vectors
// - byte/word memory loads sign-extend to 32 bits
// - misaligned word/longword access raises address error
// - immediates: sign for move/add/cmp, zero otherwise
// - arithmetic shift: 7-bit field, valid -32..+32
// - logical shift: 6-bit field, valid -16..+16
// - fixed-point source: accumulator guard used, others sign-extend
// - fixed-point result: guard kept only for accumulators
// - integer mode also drops/clears low word
// - logical mode uses bits 31..16 only
// - X/Y word transfers use upper word
// - X loads X regs, Y loads Y regs only
// - X/Y stores only from accumulator upper word
// - single move: word uses upper word, long all
// - guard fields are independent 8-bit single-move registers
// - word store from guard is sign-extended
// - word store from accumulator ignores guard
// - word load clears low word, accumulator guard sign-extends
// - guard load takes low byte, accumulator kept
// - long guard store sign-extends, long accumulator load extends
`ifndef DRO_DEFS_SVH
`define DRO_DEFS_SVH

// ==========================================================
// register byte offsets on the bus
`define DRO_OFS_STATUS 8'h00
`define DRO_OFS_VBASE 8'h04
`define DRO_OFS_DSR 8'h08
`define DRO_OFS_SP 8'h0c
`define DRO_OFS_PC 8'h10
`define DRO_OFS_DREG 8'h20

// ==========================================================
// status word layout and reset values
`define DRO_SW_IMASK_LSB 4
`define DRO_SW_XMOD_BIT 10
`define DRO_SW_YMOD_BIT 11
`define DRO_SW_RPT_LSB 16
`define DRO_SW_RST 32'h0000_00f0
`define DRO_SW_WMASK 32'h0fff_0ff3
`define DRO_VB_RST 32'h0000_0000
`define DRO_DSR_RST 32'h0000_0000
`define DRO_DSR_WMASK 32'h0000_00ff

// ==========================================================
// shift amount limits
`define DRO_ASH_LIM 8'sd32
`define DRO_LSH_LIM 8'sd16

`endif

// ===== src/dro_ext.sv
// memory load, immediate and shift-amount extension unit
`include "dro_defs.svh"

module dro_ext (
	input wire dro_pkg::dro_size_e size_i,
	input wire logic [1:0] addr_lo_i,
	input wire logic [31:0] mem_i,
	input wire dro_pkg::dro_imm_e imm_op_i,
	input wire logic [7:0] imm_i,
	input wire logic logical_shift_i,
	input wire logic [6:0] amt_i,
	output logic [31:0] load_o,
	output logic misalign_o,
	output logic [31:0] imm_o,
	output logic shift_ok_o,
	output logic [31:0] amt_o
);
	import dro_pkg::*;

	wire logic imm_zero;
	wire logic signed [7:0] ash;
	wire logic signed [7:0] lsh;

	// ==========================================================
	// memory operands, right-justified by the bus
	assign load_o = (size_i == SZ_BYTE) ? {{24{mem_i[7]}}, mem_i[7:0]} :
		(size_i == SZ_WORD) ? {{16{mem_i[15]}}, mem_i[15:0]} :
		mem_i;
	// byte anywhere, word on 2n, longword on 4n
	assign misalign_o = ((size_i == SZ_WORD) & addr_lo_i[0]) |
		((size_i == SZ_LONG) & (|addr_lo_i));

	// ==========================================================
	// logical immediates are zero-extended, so an and clears 31..8
	assign imm_zero = (imm_op_i == IMM_TEST) | (imm_op_i == IMM_AND) |
		(imm_op_i == IMM_OR) | (imm_op_i == IMM_XOR);
	assign imm_o = imm_zero ? {24'h00_0000, imm_i} :
		{{24{imm_i[7]}}, imm_i};

	// ==========================================================
	// shift amounts: field is wider than the usable range
	assign ash = {amt_i[6], amt_i};
	assign lsh = {{2{amt_i[5]}}, amt_i[5:0]};
	assign shift_ok_o = logical_shift_i ?
		((lsh >= -`DRO_LSH_LIM) && (lsh <= `DRO_LSH_LIM)) :
		((ash >= -`DRO_ASH_LIM) && (ash <= `DRO_ASH_LIM));
	assign amt_o = logical_shift_i ? {{24{lsh[7]}}, lsh} :
		{{24{ash[7]}}, ash};
endmodule

// ===== src/dro_pkg.sv
// types shared by the operand formatter files
package dro_pkg;

	typedef enum logic [3:0] {
		ACCUMULATOR_ZERO = 4'h0,
		GUARD_FIELD_ZERO = 4'h1,
		ACCUMULATOR_ONE = 4'h2,
		GUARD_FIELD_ONE = 4'h3,
		MULTIPLIER_INPUT_FIRST = 4'h4,
		MULTIPLIER_INPUT_SECOND = 4'h5,
		X_OPERAND_FIRST = 4'h6,
		X_OPERAND_SECOND = 4'h7,
		Y_OPERAND_FIRST = 4'h8,
		Y_OPERAND_SECOND = 4'h9
	} dro_reg_e;

	typedef enum logic [3:0] {
		OP_IDLE = 4'h0,
		OP_DSP_READ = 4'h1,
		OP_DSP_WRITE = 4'h2,
		OP_X_LOAD = 4'h3,
		OP_Y_LOAD = 4'h4,
		OP_XY_STORE = 4'h5,
		OP_SINGLE_LOAD = 4'h6,
		OP_SINGLE_STORE = 4'h7,
		OP_MEM_LOAD = 4'h8,
		OP_IMM = 4'h9,
		OP_SHIFT = 4'ha
	} dro_op_e;

	typedef enum logic [1:0] {
		FMT_FIXED = 2'h0,
		FMT_INTEGER = 2'h1,
		FMT_LOGICAL = 2'h2
	} dro_fmt_e;

	typedef enum logic [1:0] {
		SZ_BYTE = 2'h0,
		SZ_WORD = 2'h1,
		SZ_LONG = 2'h2
	} dro_size_e;

	typedef enum logic [2:0] {
		IMM_MOVE = 3'h0,
		IMM_ADD = 3'h1,
		IMM_COMPARE_EQUAL = 3'h2,
		IMM_TEST = 3'h3,
		IMM_AND = 3'h4,
		IMM_OR = 3'h5,
		IMM_XOR = 3'h6
	} dro_imm_e;

	typedef enum logic [1:0] {
		ST_VECTOR = 2'b01,
		ST_RUN = 2'b10
	} dro_state_e;

	typedef struct packed {
		logic valid;
		dro_op_e op;
		dro_fmt_e fmt;
		dro_reg_e src;
		dro_reg_e dst;
		logic longword;
		dro_size_e size;
		dro_imm_e imm_op;
		logic logical_shift;
		logic [31:0] addr;
		logic [39:0] data;
	} dro_req_s;

	typedef struct packed {
		logic done;
		logic refused;
		logic addr_err;
		logic shift_ok;
		logic [39:0] operand;
		logic [31:0] data;
	} dro_rsp_s;

endpackage

// ===== src/dro_regfile.sv
// DSP and control register file with operand formatting
//
// Our own choices: the address map and the Wishbone interface to the registers.
`include "dro_defs.svh"

module dro_regfile (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic ce_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic [31:0] vec_sp_i,
	input wire logic [31:0] vec_pc_i,
	input wire dro_pkg::dro_req_s req_i,
	output dro_pkg::dro_rsp_s rsp_o,
	output logic [31:0] status_word_o,
	output logic [31:0] vector_base_o,
	output logic [31:0] stack_pointer_gpr_o
);
	import dro_pkg::*;

	// ==========================================================
	// helper decoders, used by both the bus and the pipeline
	function automatic logic [2:0] slot_of(input dro_reg_e r);
		case (r)
			ACCUMULATOR_ZERO, GUARD_FIELD_ZERO: slot_of = 3'h0;
			ACCUMULATOR_ONE, GUARD_FIELD_ONE: slot_of = 3'h1;
			MULTIPLIER_INPUT_FIRST: slot_of = 3'h2;
			MULTIPLIER_INPUT_SECOND: slot_of = 3'h3;
			X_OPERAND_FIRST: slot_of = 3'h4;
			X_OPERAND_SECOND: slot_of = 3'h5;
			Y_OPERAND_FIRST: slot_of = 3'h6;
			default: slot_of = 3'h7;
		endcase
	endfunction

	function automatic logic is_acc(input dro_reg_e r);
		is_acc = (r == ACCUMULATOR_ZERO) | (r == ACCUMULATOR_ONE);
	endfunction

	function automatic logic is_guard(input dro_reg_e r);
		is_guard = (r == GUARD_FIELD_ZERO) | (r == GUARD_FIELD_ONE);
	endfunction

	// byte-lane merge for wishbone writes
	function automatic logic [31:0] merge(input logic [31:0] old_v,
		input logic [31:0] new_v, input logic [3:0] sel);
		merge = old_v;
		for (int b = 0; b < 4; b++)
		begin
			if (sel[b])
			begin
				merge[8*b +: 8] = new_v[8*b +: 8];
			end
		end
	endfunction

	// ==========================================================
	// state
	dro_state_e state_q;
	logic [31:0] dreg_q [0:7];
	logic [7:0] guard_q [0:1];
	logic [31:0] status_q;
	logic [31:0] vbase_q;
	logic [31:0] dsr_q;
	logic [31:0] sp_q;
	logic [31:0] pc_q;
	logic ack_q;
	logic [31:0] dat_q;
	logic [31:0] dat_d;
	dro_rsp_s rsp_q;
	dro_rsp_s rsp_d;

	// ==========================================================
	// bus decode
	wire logic bus_hit = wb_cyc_i & wb_stb_i & ~ack_q;
	wire logic bus_wr = bus_hit & wb_we_i & ce_i;
	wire logic [5:0] bus_idx = wb_adr_i[7:2];
	wire logic [5:0] dreg_base = 6'(`DRO_OFS_DREG >> 2);
	wire logic [5:0] bus_rel = bus_idx - dreg_base;
	wire logic bus_dsp = (bus_idx >= dreg_base) && (bus_rel < 6'd10);
	wire dro_reg_e bus_reg = dro_reg_e'(bus_rel[3:0]);
	wire logic bus_wr_word = bus_wr & bus_dsp & ~is_guard(bus_reg);
	wire logic bus_wr_grd = bus_wr & bus_dsp & is_guard(bus_reg) &
		wb_sel_i[0];
	wire logic [2:0] bus_slot = slot_of(bus_reg);
	wire logic wr_status = bus_wr & (bus_idx == 6'(`DRO_OFS_STATUS >> 2));
	wire logic wr_vbase = bus_wr & (bus_idx == 6'(`DRO_OFS_VBASE >> 2));
	wire logic wr_dsr = bus_wr & (bus_idx == 6'(`DRO_OFS_DSR >> 2));
	wire logic wr_sp = bus_wr & (bus_idx == 6'(`DRO_OFS_SP >> 2));
	wire logic wr_pc = bus_wr & (bus_idx == 6'(`DRO_OFS_PC >> 2));

	// ==========================================================
	// request classification
	wire logic go = req_i.valid & ce_i & (state_q == ST_RUN);
	wire logic is_dr = req_i.op == OP_DSP_READ;
	wire logic is_dw = req_i.op == OP_DSP_WRITE;
	wire logic is_xl = req_i.op == OP_X_LOAD;
	wire logic is_yl = req_i.op == OP_Y_LOAD;
	wire logic is_xys = req_i.op == OP_XY_STORE;
	wire logic is_sl = req_i.op == OP_SINGLE_LOAD;
	wire logic is_ss = req_i.op == OP_SINGLE_STORE;
	wire logic is_ml = req_i.op == OP_MEM_LOAD;
	wire logic is_im = req_i.op == OP_IMM;
	wire logic is_sh = req_i.op == OP_SHIFT;
	wire logic src_acc = is_acc(req_i.src);
	wire logic src_grd = is_guard(req_i.src);
	wire logic dst_acc = is_acc(req_i.dst);
	wire logic dst_grd = is_guard(req_i.dst);
	wire logic x_dst = (req_i.dst == X_OPERAND_FIRST) |
		(req_i.dst == X_OPERAND_SECOND);
	wire logic y_dst = (req_i.dst == Y_OPERAND_FIRST) |
		(req_i.dst == Y_OPERAND_SECOND);

	// X loads take only the two X registers, Y loads only the two Y registers
	wire logic refuse = (is_dr & src_grd) | (is_dw & dst_grd) |
		(is_xl & ~x_dst) | (is_yl & ~y_dst) |
		(is_xys & ~src_acc);

	// ==========================================================
	// source views
	wire logic [31:0] src_word = dreg_q[slot_of(req_i.src)];
	wire logic [7:0] src_guard = guard_q[slot_of(req_i.src) == 3'h1];
	wire logic [39:0] src_ext = src_acc ? {src_guard, src_word} :
		{{8{src_word[31]}}, src_word};
	// integer mode drops the low word, logical keeps only 31..16
	wire logic [39:0] dsp_operand =
		(req_i.fmt == FMT_LOGICAL) ?
		{8'h00, src_word[31:16], 16'h0000} :
		(req_i.fmt == FMT_INTEGER) ?
		{src_ext[39:16], 16'h0000} :
		src_ext;
	// guard store: 8 bits sign-extended in either mode
	wire logic [31:0] grd_store = {{24{src_guard[7]}}, src_guard};
	wire logic [31:0] single_store = src_grd ? grd_store :
		req_i.longword ? src_word :
		{{16{src_word[31]}}, src_word[31:16]};
	wire logic [31:0] xy_store = {16'h0000, src_word[31:16]};

	// ==========================================================
	// destination values
	wire logic [39:0] d = req_i.data;
	wire logic [31:0] wr_word_val =
		is_dw ? ((req_i.fmt == FMT_FIXED) ? d[31:0] :
		{d[31:16], 16'h0000}) :
		(is_sl & req_i.longword) ? d[31:0] :
		{d[15:0], 16'h0000};
	wire logic [7:0] wr_guard_val =
		is_dw ? ((req_i.fmt == FMT_LOGICAL) ? 8'h00 :
		d[39:32]) :
		dst_grd ? d[7:0] :
		req_i.longword ? {8{d[31]}} :
		{8{d[15]}};
	// guard loads leave the accumulator's 32-bit part untouched
	wire logic wr_word_en = go & ~refuse & ~dst_grd &
		(is_dw | is_xl | is_yl | is_sl);
	wire logic wr_guard_en = go & ~refuse &
		(((is_dw | is_sl) & dst_acc) | (is_sl & dst_grd));
	wire logic [2:0] wr_slot = slot_of(req_i.dst);

	// ==========================================================
	// extension unit
	wire logic [31:0] ext_load;
	wire logic ext_misalign;
	wire logic [31:0] ext_imm;
	wire logic ext_shift_ok;
	wire logic [31:0] ext_amt;

	dro_ext u_ext (
		.size_i(req_i.size),
		.addr_lo_i(req_i.addr[1:0]),
		.mem_i(d[31:0]),
		.imm_op_i(req_i.imm_op),
		.imm_i(d[7:0]),
		.logical_shift_i(req_i.logical_shift),
		.amt_i(d[6:0]),
		.load_o(ext_load),
		.misalign_o(ext_misalign),
		.imm_o(ext_imm),
		.shift_ok_o(ext_shift_ok),
		.amt_o(ext_amt)
	);

	// ==========================================================
	// response of the request taken this cycle
	assign rsp_d.done = go & (req_i.op != OP_IDLE);
	assign rsp_d.refused = go & refuse;
	assign rsp_d.addr_err = go & is_ml & ext_misalign;
	assign rsp_d.shift_ok = go & is_sh & ext_shift_ok;
	assign rsp_d.operand = (go & is_dr & ~refuse) ? dsp_operand : 40'h0;
	assign rsp_d.data = ~go ? 32'h0 :
		is_ss ? single_store :
		(is_xys & ~refuse) ? xy_store :
		is_ml ? ext_load :
		is_im ? ext_imm :
		is_sh ? ext_amt :
		32'h0;

	// ==========================================================
	// bus read mux; unmapped words read as zero
	always_comb
	begin
		dat_d = 32'h0;
		if (bus_dsp)
		begin
			dat_d = is_guard(bus_reg) ?
				{24'h00_0000, guard_q[bus_slot == 3'h1]} :
				dreg_q[bus_slot];
		end
		else
		begin
			case (bus_idx)
				6'(`DRO_OFS_STATUS >> 2): dat_d = status_q;
				6'(`DRO_OFS_VBASE >> 2): dat_d = vbase_q;
				6'(`DRO_OFS_DSR >> 2): dat_d = dsr_q;
				6'(`DRO_OFS_SP >> 2): dat_d = sp_q;
				6'(`DRO_OFS_PC >> 2): dat_d = pc_q;
				default: dat_d = 32'h0;
			endcase
		end
	end

	// ==========================================================
	// data registers: no reset, contents are arbitrary until written
	// the pipeline wins over a bus write to the same register
	for (genvar i = 0; i < 8; i++)
	begin : g_dreg
		always_ff @(posedge clk_i)
		begin
			if (wr_word_en && wr_slot == 3'(i))
			begin
				dreg_q[i] <= wr_word_val;
			end
			else if (bus_wr_word && bus_slot == 3'(i))
			begin
				dreg_q[i] <= merge(dreg_q[i], wb_dat_i, wb_sel_i);
			end
		end
	end

	for (genvar g = 0; g < 2; g++)
	begin : g_guard
		always_ff @(posedge clk_i)
		begin
			if (wr_guard_en && wr_slot == 3'(g))
			begin
				guard_q[g] <= wr_guard_val;
			end
			else if (bus_wr_grd && bus_slot == 3'(g))
			begin
				guard_q[g] <= wb_dat_i[7:0];
			end
		end
	end

	// ==========================================================
	// control registers and start-up sequence
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			state_q <= ST_VECTOR;
			status_q <= `DRO_SW_RST;
			vbase_q <= `DRO_VB_RST;
			dsr_q <= `DRO_DSR_RST;
		end
		else if (ce_i)
		begin
			case (state_q)
				ST_VECTOR: state_q <= ST_RUN;
				ST_RUN: state_q <= ST_RUN;
				default: state_q <= ST_VECTOR;
			endcase
			if (wr_status)
			begin
				status_q <= merge(status_q, wb_dat_i, wb_sel_i) &
					`DRO_SW_WMASK;
			end
			if (wr_vbase)
			begin
				vbase_q <= merge(vbase_q, wb_dat_i, wb_sel_i);
			end
			if (wr_dsr)
			begin
				dsr_q <= merge(dsr_q, wb_dat_i, wb_sel_i) & `DRO_DSR_WMASK;
			end
		end
	end

	// stack pointer and pc come from the vector table after reset
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			sp_q <= 32'h0;
			pc_q <= 32'h0;
		end
		else if (ce_i && state_q == ST_VECTOR)
		begin
			sp_q <= vec_sp_i;
			pc_q <= vec_pc_i;
		end
		else if (ce_i)
		begin
			if (wr_sp)
			begin
				sp_q <= merge(sp_q, wb_dat_i, wb_sel_i);
			end
			if (wr_pc)
			begin
				pc_q <= merge(pc_q, wb_dat_i, wb_sel_i);
			end
		end
	end

	// ==========================================================
	// bus answer one cycle after the request, response pulse
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			ack_q <= 1'b0;
			dat_q <= 32'h0;
			rsp_q <= '0;
		end
		else if (ce_i)
		begin
			ack_q <= bus_hit;
			dat_q <= bus_hit ? dat_d : 32'h0;
			rsp_q <= rsp_d;
		end
	end

	assign wb_ack_o = ack_q;
	assign wb_dat_o = dat_q;
	assign rsp_o = rsp_q;
	assign status_word_o = status_q;
	assign vector_base_o = vbase_q;
	assign stack_pointer_gpr_o = sp_q;
endmodule

// ===== verif/dro_pipe_model.sv
// execution pipeline and vector table model that feeds the formatter
module dro_pipe_model #(
	parameter logic [31:0] VEC_SP = 32'h0000_2000,
	parameter logic [31:0] VEC_PC = 32'h0000_0400
) (
	input wire logic clk_i,
	output dro_pkg::dro_req_s req_o,
	output logic [31:0] vec_sp_o,
	output logic [31:0] vec_pc_o
);
	timeunit 1ns;
	timeprecision 1ps;
	import dro_pkg::*;
	// software keeps the stack pointer on a longword boundary
	assign vec_sp_o = {VEC_SP[31:2], 2'h0};
	assign vec_pc_o = VEC_PC;
	// no request at time zero
	initial
	begin
		req_o = '0;
	end
	// one request per edge; back to back calls keep valid high
	task automatic issue(input dro_req_s r);
		@(posedge clk_i);
		req_o <= r;
	endtask
	// idle data lines flip so a stale value is never mistaken for fresh
	task automatic idle();
		@(posedge clk_i);
		req_o.valid <= 1'b0;
		req_o.data <= ~req_o.data;
	endtask
endmodule

// ===== verif/dro_regfile_sva.sv
// concurrent checks on the ports of the operand formatter register file
module dro_regfile_sva (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic ce_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_ack_o,
	input wire logic [31:0] vec_sp_i,
	input wire dro_pkg::dro_req_s req_i,
	input wire dro_pkg::dro_rsp_s rsp_o,
	input wire logic [31:0] status_word_o,
	input wire logic [31:0] vector_base_o,
	input wire logic [31:0] stack_pointer_gpr_o
);
	timeunit 1ns;
	timeprecision 1ps;
	import dro_pkg::*;
	logic run_q;
	logic req_go;
	logic mis;
	logic signed [7:0] amt;
	logic sh_ok;
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	// ==========================================================
	// helper logic
	// requests count only once the vector load edge has gone by
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			run_q <= 1'b0;
		else if (ce_i)
			run_q <= 1'b1;
	end
	// expected alignment fault and shift range, from the request alone
	assign req_go = req_i.valid && ce_i && run_q;
	assign mis = (req_i.size == SZ_WORD && req_i.addr[0]) ||
		(req_i.size == SZ_LONG && req_i.addr[1:0] != 2'h0);
	assign amt = req_i.logical_shift ?
		{{2{req_i.data[5]}}, req_i.data[5:0]} : {req_i.data[6], req_i.data[6:0]};
	assign sh_ok = req_i.logical_shift ? (amt >= -8'sd16 && amt <= 8'sd16) :
		(amt >= -8'sd32 && amt <= 8'sd32);

	// ==========================================================
	// assertions
	a_reset_status: assert property (disable iff (1'b0)
		rst_i && ce_i |=> status_word_o == 32'h0000_00f0)
		else $error("status word wrong after reset");
	a_reset_vbase: assert property (disable iff (1'b0)
		rst_i && ce_i |=> vector_base_o == 32'h0)
		else $error("vector base not cleared by reset");
	a_vector_load: assert property ($past(rst_i) && !rst_i && ce_i
		|=> stack_pointer_gpr_o == $past(vec_sp_i))
		else $error("stack pointer not loaded from vector");
	a_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o && ce_i
		|=> wb_ack_o) else $error("bus access not acknowledged");
	a_ack_single: assert property (wb_ack_o && ce_i |=> !wb_ack_o)
		else $error("ack longer than one cycle");
	a_done_timing: assert property (req_go |=> rsp_o.done)
		else $error("request not answered next cycle");
	a_imm_zero: assert property (req_go && req_i.op == OP_IMM &&
		req_i.imm_op inside {IMM_TEST, IMM_AND, IMM_OR, IMM_XOR}
		|=> rsp_o.data == {24'h0, $past(req_i.data[7:0])})
		else $error("immediate not zero-extended");
	a_imm_sign: assert property (req_go && req_i.op == OP_IMM &&
		!(req_i.imm_op inside {IMM_TEST, IMM_AND, IMM_OR, IMM_XOR})
		|=> rsp_o.data == {{24{$past(req_i.data[7])}}, $past(req_i.data[7:0])})
		else $error("immediate not sign-extended");
	a_misalign_flag: assert property (req_go && req_i.op == OP_MEM_LOAD
		|=> rsp_o.addr_err == $past(mis)) else $error("alignment flag wrong");
	a_shift_range: assert property (req_go && req_i.op == OP_SHIFT
		|=> rsp_o.shift_ok == $past(sh_ok)) else $error("shift range flag wrong");
	a_store_source: assert property (req_go && req_i.op == OP_XY_STORE &&
		!(req_i.src inside {ACCUMULATOR_ZERO, ACCUMULATOR_ONE})
		|=> rsp_o.refused && rsp_o.data == 32'h0)
		else $error("store from non-accumulator accepted");
endmodule

bind dro_regfile dro_regfile_sva u_sva (.clk_i(clk_i), .rst_i(rst_i),
	.ce_i(ce_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
	.wb_ack_o(wb_ack_o), .vec_sp_i(vec_sp_i), .req_i(req_i), .rsp_o(rsp_o),
	.status_word_o(status_word_o), .vector_base_o(vector_base_o),
	.stack_pointer_gpr_o(stack_pointer_gpr_o));

// ===== verif/testbench.sv
// self-checking bench for the DSP register operand formatter
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	import dro_pkg::*;
	localparam logic [31:0] VSP = 32'h0000_2000;
	localparam logic [31:0] VPC = 32'h0000_0400;
	logic clk_i, rst_i, ce_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
	logic [3:0] wb_sel_i;
	logic [7:0] wb_adr_i;
	logic [31:0] wb_dat_i, wb_dat_o, vec_sp_i, vec_pc_i, sw_o, vb_o, sp_o;
	dro_req_s req_i, r;
	dro_rsp_s rsp_o;
	logic [32:0] bus_q[$];
	logic [42:0] rsp_q[$];
	logic [32:0] be;
	logic [42:0] re;
	logic [39:0] e;
	logic [6:0] amt;
	logic [7:0] b;
	int s;
	int num_errors = 0;
	int samples_checked = 0;

	// ==========================================================
	// clock and instances
	initial
	begin
		clk_i = 1'b0;
		forever #10 clk_i = ~clk_i;
	end
	dro_regfile DUT (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i),
		.wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
		.wb_sel_i(wb_sel_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i),
		.wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .vec_sp_i(vec_sp_i),
		.vec_pc_i(vec_pc_i), .req_i(req_i), .rsp_o(rsp_o),
		.status_word_o(sw_o), .vector_base_o(vb_o), .stack_pointer_gpr_o(sp_o));
	dro_pipe_model #(.VEC_SP(VSP), .VEC_PC(VPC)) u_pipe (.clk_i(clk_i),
		.req_o(req_i), .vec_sp_o(vec_sp_i), .vec_pc_o(vec_pc_i));

	// ==========================================================
	// compare, verdict and drivers
	task automatic cmp_bus(input logic [31:0] x, input logic [31:0] g);
		samples_checked++;
		if (g !== x)
		begin
			num_errors++;
			$display("unexpected bus data at %0t: exp %h got %h", $time, x, g);
		end
	endtask
	task automatic cmp_rsp(input logic [39:0] x, input logic [39:0] g);
		samples_checked++;
		if (g !== x)
		begin
			num_errors++;
			$display("unexpected answer at %0t: exp %h got %h", $time, x, g);
		end
	endtask
	task automatic give_verdict();
		num_errors += rsp_q.size() + bus_q.size();
		$display("compared %0d, mismatched %0d", samples_checked, num_errors);
		if (num_errors == 0 && samples_checked > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	// one classic cycle, held until ack is seen; notes the read it expects
	task automatic bus(input logic w, input logic [7:0] a, input logic [3:0] m,
		input logic [31:0] d, input logic [31:0] x);
		int n;
		n = 0;
		bus_q.push_back({!w, x});
		@(posedge clk_i);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= w;
		wb_adr_i <= a;
		wb_sel_i <= m;
		wb_dat_i <= d;
		do
		begin
			@(posedge clk_i);
			n++;
		end
		while (wb_ack_o !== 1'b1 && n < 50);
		num_errors += (n == 50);
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
	endtask
	// kind: 0 data, 1 operand, 2 refused, 3 address fault, 4 shift ok, 5 none
	task automatic rq(input dro_op_e op, input dro_reg_e g, input logic lw,
		input logic [39:0] d, input logic [2:0] k, input logic [39:0] x);
		r.valid = 1'b1;
		r.op = op;
		r.src = g;
		r.dst = g;
		r.longword = lw;
		r.data = d;
		rsp_q.push_back({k, x});
		u_pipe.issue(r);
	endtask
	function automatic logic [39:0] pick(input logic [2:0] k);
		case (k)
			3'h0: return {8'h0, rsp_o.data};
			3'h1: return rsp_o.operand;
			3'h2: return {39'h0, rsp_o.refused};
			3'h3: return {39'h0, rsp_o.addr_err};
			default: return {39'h0, rsp_o.shift_ok};
		endcase
	endfunction
	// each answer retires the oldest note of its interface
	always @(posedge clk_i)
	begin
		if (wb_ack_o === 1'b1 && bus_q.size() > 0)
		begin
			be = bus_q.pop_front();
			if (be[32])
				cmp_bus(be[31:0], wb_dat_o);
		end
		if (rsp_o.done === 1'b1 && rsp_q.size() > 0)
		begin
			re = rsp_q.pop_front();
			if (re[42:40] != 3'h5)
				cmp_rsp(re[39:0], pick(re[42:40]));
		end
	end
	// the tests need about 130 cycles, so this only ends a hang
	initial
	begin
		repeat (5000) @(posedge clk_i);
		num_errors++;
		give_verdict();
	end

	// ==========================================================
	// scenarios
	initial
	begin
		void'($urandom(32'ha3d73c20));
		{rst_i, ce_i} = 2'b11;
		{wb_cyc_i, wb_stb_i, wb_we_i, wb_sel_i, wb_adr_i, wb_dat_i} = '0;
		r = '0;
		repeat (4) @(posedge clk_i);
		rst_i <= 1'b0;
		bus(0, 8'h00, 4'hf, 0, 32'h0000_00f0);
		bus(0, 8'h04, 4'hf, 0, 32'h0);
		bus(0, 8'h08, 4'hf, 0, 32'h0);
		bus(0, 8'h0c, 4'hf, 0, VSP);
		bus(0, 8'h10, 4'hf, 0, VPC);
		bus(1, 8'h00, 4'hf, 32'hffff_ffff, 0);
		bus(0, 8'h00, 4'hf, 0, 32'h0fff_0ff3);
		bus(1, 8'h08, 4'hf, 32'hffff_ffff, 0);
		bus(0, 8'h08, 4'hf, 0, 32'h0000_00ff);
		bus(1, 8'h04, 4'h1, 32'haabb_ccdd, 0);
		bus(0, 8'h04, 4'hf, 0, 32'h0000_00dd);
		bus(1, 8'hfc, 4'hf, 32'h1, 0);
		bus(0, 8'hfc, 4'hf, 0, 32'h0);
		rq(OP_SINGLE_LOAD, ACCUMULATOR_ZERO, 0, 40'h8001, 3'h5, 0);
		rq(OP_SINGLE_STORE, GUARD_FIELD_ZERO, 0, 0, 0, 40'hffff_ffff);
		rq(OP_SINGLE_LOAD, GUARD_FIELD_ZERO, 0, 40'h1234, 3'h5, 0);
		rq(OP_SINGLE_STORE, GUARD_FIELD_ZERO, 0, 0, 0, 40'h34);
		rq(OP_SINGLE_STORE, ACCUMULATOR_ZERO, 0, 0, 0, 40'hffff_8001);
		rq(OP_SINGLE_STORE, ACCUMULATOR_ZERO, 1, 0, 0, 40'h8001_0000);
		rq(OP_SINGLE_LOAD, ACCUMULATOR_ONE, 1, 40'hc000_0000, 3'h5, 0);
		rq(OP_SINGLE_STORE, GUARD_FIELD_ONE, 1, 0, 0, 40'hffff_ffff);
		rq(OP_DSP_READ, ACCUMULATOR_ONE, 0, 0, 1, 40'hff_c000_0000);
		r.fmt = FMT_LOGICAL;
		rq(OP_DSP_READ, ACCUMULATOR_ONE, 0, 0, 1, 40'h00_c000_0000);
		r.fmt = FMT_INTEGER;
		rq(OP_SINGLE_LOAD, X_OPERAND_SECOND, 1, 40'h1234_abcd, 3'h5, 0);
		rq(OP_DSP_READ, X_OPERAND_SECOND, 0, 0, 1, 40'h00_1234_0000);
		rq(OP_DSP_WRITE, ACCUMULATOR_ZERO, 0, 40'h01_2345_6789, 3'h5, 0);
		rq(OP_SINGLE_STORE, ACCUMULATOR_ZERO, 1, 0, 0, 40'h2345_0000);
		r.fmt = FMT_FIXED;
		rq(OP_DSP_WRITE, X_OPERAND_FIRST, 0, 40'h12_8000_0005, 3'h5, 0);
		rq(OP_DSP_READ, X_OPERAND_FIRST, 0, 0, 1, 40'hff_8000_0005);
		rq(OP_DSP_WRITE, ACCUMULATOR_ONE, 0, 40'h12_8765_4321, 3'h5, 0);
		rq(OP_SINGLE_STORE, GUARD_FIELD_ONE, 1, 0, 0, 40'h12);
		r.fmt = FMT_LOGICAL;
		rq(OP_DSP_WRITE, ACCUMULATOR_ONE, 0, 40'h12_8765_4321, 3'h5, 0);
		rq(OP_SINGLE_STORE, ACCUMULATOR_ONE, 1, 0, 0, 40'h8765_0000);
		rq(OP_SINGLE_STORE, GUARD_FIELD_ONE, 1, 0, 0, 40'h0);
		rq(OP_X_LOAD, X_OPERAND_FIRST, 0, 40'h8000, 3'h5, 0);
		rq(OP_SINGLE_STORE, X_OPERAND_FIRST, 1, 0, 0, 40'h8000_0000);
		rq(OP_X_LOAD, Y_OPERAND_FIRST, 0, 40'h1, 2, 40'h1);
		rq(OP_Y_LOAD, Y_OPERAND_SECOND, 0, 40'hbeef, 3'h5, 0);
		rq(OP_SINGLE_STORE, Y_OPERAND_SECOND, 1, 0, 0, 40'hbeef_0000);
		rq(OP_XY_STORE, Y_OPERAND_SECOND, 0, 0, 2, 40'h1);
		rq(OP_XY_STORE, ACCUMULATOR_ZERO, 0, 0, 0, 40'h2345);
		rq(OP_DSP_READ, GUARD_FIELD_ONE, 0, 0, 2, 40'h1);
		// with the enable low a request must neither write nor answer
		u_pipe.idle();
		u_pipe.idle();
		ce_i <= 1'b0;
		r.op = OP_Y_LOAD;
		r.dst = Y_OPERAND_SECOND;
		r.data = 40'h1111;
		u_pipe.issue(r);
		u_pipe.idle();
		ce_i <= 1'b1;
		rq(OP_SINGLE_STORE, Y_OPERAND_SECOND, 1, 0, 0, 40'hbeef_0000);
		// every immediate kind, with the sign bit set so the two differ
		for (int i = 0; i < 7; i++)
		begin
			b = 8'($urandom()) | 8'h80;
			r.imm_op = dro_imm_e'(i);
			e = {32'h0, b};
			if (i < 3)
				e[31:8] = 24'hff_ffff;
			rq(OP_IMM, ACCUMULATOR_ZERO, 0, {32'h0, b}, 0, e);
		end
		// each end of both shift ranges and one step past it
		for (int i = 0; i < 8; i++)
		begin
			s = (i[2] ? 16 : 32) + i[0];
			s = i[1] ? -s : s;
			amt = 7'(s);
			amt[6] = i[2] ? 1'($urandom()) : amt[6];
			r.logical_shift = i[2];
			e = i[2] ? {8'h0, {26{amt[5]}}, amt[5:0]} : {8'h0, {25{amt[6]}}, amt};
			rq(OP_SHIFT, ACCUMULATOR_ZERO, 0, {33'h0, amt}, 4, {39'h0, !i[0]});
			rq(OP_SHIFT, ACCUMULATOR_ZERO, 0, {33'h0, amt}, 0, e);
		end
		// every size at every low address bit pattern
		for (int i = 0; i < 12; i++)
		begin
			r.size = dro_size_e'(i / 4);
			r.addr = {30'($urandom()), 2'(i)};
			rq(OP_MEM_LOAD, ACCUMULATOR_ZERO, 0, 40'h8080_8080, 3,
				{39'h0, (i >= 4 && i[0]) || (i >= 8 && i[1])});
		end
		r.size = SZ_BYTE;
		rq(OP_MEM_LOAD, ACCUMULATOR_ZERO, 0, 40'h8080_8080, 0, 40'hffff_ff80);
		r.size = SZ_WORD;
		r.addr = 32'h0;
		rq(OP_MEM_LOAD, ACCUMULATOR_ZERO, 0, 40'h8001_8001, 0, 40'hffff_8001);
		u_pipe.idle();
		repeat (4) @(posedge clk_i);
		rst_i <= 1'b1;
		@(posedge clk_i);
		rst_i <= 1'b0;
		bus(0, 8'h00, 4'hf, 0, 32'h0000_00f0);
		bus(0, 8'h0c, 4'hf, 0, VSP);
		repeat (4) @(posedge clk_i);
		give_verdict();
	end
endmodule
